// >>> rtl/ifp_defines.svh
// Register offsets, field positions, reset values and interrupt numbers
//
// Functional notes
// R1 - Sleep timer pending flag, bit 7, four
// R2 - Port 0 pending flag, bit 5, four
// R3 - Timer flags bits 4..1, cleared on vectoring
// R4 - DMA done pending flag, bit 0, four
// R5 - Watchdog pending flag, bit 4, five
// R6 - Port 1 pending flag, bit 3, five
// R7 - USART transmit flags, bits 2 and 1
// R8 - Port 2 pending flag, bit 0, five
// R9 - Sources split into six priority groups
// R10 - Group n level bits from bit n
// R11 - Level pair 00 lowest, 11 highest
// R12 - Same or lower level never preempts
// R13 - Equal levels resolved by fixed polling
// R14 - Fixed membership of sources in groups
// R15 - Fixed polling order over eighteen sources
// R16 - Software clears other flags by writing 0
`ifndef IFP_DEFINES_SVH
`define IFP_DEFINES_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define IFP_OFS_PRIO_LOW   8'ha9
`define IFP_OFS_PRIO_HIGH  8'hb9
`define IFP_OFS_FLAGS_FOUR 8'hc0
`define IFP_OFS_FLAGS_FIVE 8'he8
`define IFP_RST_PRIO       8'h00
`define IFP_RST_FLAGS      8'h00
`define IFP_MASK_PRIO      8'h3f
`define IFP_MASK_FOUR      8'hbf
`define IFP_MASK_FIVE      8'h1f

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define IFP_B4_SLEEP 7
`define IFP_B4_PORT0 5
`define IFP_B4_T4    4
`define IFP_B4_T3    3
`define IFP_B4_T2    2
`define IFP_B4_T1    1
`define IFP_B4_DMA   0
`define IFP_B5_WDT   4
`define IFP_B5_PORT1 3
`define IFP_B5_UTX1  2
`define IFP_B5_UTX0  1
`define IFP_B5_PORT2 0

// ---------------------------------------------------------------
// Sizes and interrupt numbers
// ---------------------------------------------------------------
`define IFP_NUM_SRC 18
`define IFP_NUM_GRP 6
`define IFP_NUM_LVL 4
`define IFP_N_RADIO_TXRX_DONE_SOURCE 5'h00
`define IFP_N_ADC    5'h01
`define IFP_N_URX0   5'h02
`define IFP_N_URX1   5'h03
`define IFP_N_AES    5'h04
`define IFP_N_SLEEP  5'h05
`define IFP_N_P2     5'h06
`define IFP_N_UTX0   5'h07
`define IFP_N_DMA    5'h08
`define IFP_N_T1     5'h09
`define IFP_N_T2     5'h0a
`define IFP_N_T3     5'h0b
`define IFP_N_T4     5'h0c
`define IFP_N_P0     5'h0d
`define IFP_N_UTX1   5'h0e
`define IFP_N_P1     5'h0f
`define IFP_N_RF     5'h10
`define IFP_N_WDT    5'h11

`endif

// >>> rtl/ifp_pkg.sv
// Types shared by the interrupt flag and priority block
`include "ifp_defines.svh"
package ifp_pkg;
   typedef logic [1:0]              ifp_lvl_t;
   typedef logic [4:0]              ifp_num_t;
   typedef logic [2:0]              ifp_grp_t;
   typedef logic [`IFP_NUM_SRC-1:0] ifp_src_vec_t;
   typedef logic [`IFP_NUM_GRP-1:0] ifp_grp_vec_t;
   typedef logic [7:0]              ifp_byte_t;
endpackage

// >>> rtl/ifp_flag_bit.sv
// One pending flag: hardware set, software write, optional hardware clear
`timescale 1ns/1ns
module ifp_flag_bit (
   // Clock, reset, enable
   input  logic clk_sys_i,
   input  logic resetn_i,
   input  logic ce_i,
   // Flag controls
   input  logic set_i,
   input  logic wr_i,
   input  logic wdata_i,
   input  logic hw_clr_i,
   // Flag value
   output logic flag_o
);
   logic flag_reg;
   logic flag_next;

   // Set wins over any clear so an event in the clearing cycle is kept
   assign flag_next = set_i | (wr_i ? wdata_i : (flag_reg & ~hw_clr_i));

   // Flag store
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flag_reg <= 1'b0;
      end else if (ce_i) begin
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;
endmodule

// >>> rtl/ifp_arbiter.sv
// Picks the highest level pending source, polling order breaks ties
`timescale 1ns/1ns
`include "ifp_defines.svh"
module ifp_arbiter
   import ifp_pkg::*;
(
   // Requests indexed by interrupt number
   input  ifp_src_vec_t pend_i,
   // Group level bits
   input  ifp_grp_vec_t lvl_low_i,
   input  ifp_grp_vec_t lvl_high_i,
   // Winner
   output logic         valid_o,
   output ifp_num_t     num_o,
   output ifp_lvl_t     lvl_o
);
   // Polling sequence, first entry wins among equal levels
   localparam ifp_num_t POLL_ORDER [`IFP_NUM_SRC] = '{
      `IFP_N_RADIO_TXRX_DONE_SOURCE, `IFP_N_RF, `IFP_N_DMA, `IFP_N_ADC, `IFP_N_T1, `IFP_N_URX0,
      `IFP_N_T2, `IFP_N_URX1, `IFP_N_T3, `IFP_N_AES, `IFP_N_T4, `IFP_N_SLEEP,
      `IFP_N_P0, `IFP_N_P2, `IFP_N_UTX0, `IFP_N_UTX1, `IFP_N_P1, `IFP_N_WDT};

   // Group of each source, indexed by interrupt number
   localparam ifp_grp_t GROUP_OF [`IFP_NUM_SRC] = '{
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
      3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};

   ifp_lvl_t src_lvl [`IFP_NUM_SRC];

   // Level of each source from its group's bit pair
   for (genvar gi = 0; gi < `IFP_NUM_SRC; gi++) begin : g_lvl
      assign src_lvl[gi] = {lvl_high_i[GROUP_OF[gi]], lvl_low_i[GROUP_OF[gi]]}; // [R10] [R11] [R14]
   end

   // Strictly higher level replaces the winner, so earlier polls keep ties
   always_comb begin
      valid_o = 1'b0;
      num_o   = '0;
      lvl_o   = '0;
      for (int p = 0; p < `IFP_NUM_SRC; p++) begin
         if (pend_i[POLL_ORDER[p]] && (!valid_o || src_lvl[POLL_ORDER[p]] > lvl_o)) begin
            valid_o = 1'b1;                 // [R13] [R15]
            num_o   = POLL_ORDER[p];
            lvl_o   = src_lvl[POLL_ORDER[p]];
         end
      end
   end
endmodule

// >>> rtl/ifp_top.sv
// Interrupt pending flags, group priorities and preemption control
`timescale 1ns/1ns
`include "ifp_defines.svh"
module ifp_top
   import ifp_pkg::*;
(
   // Clock, reset, enable
   input  logic      clk_sys_i,
   input  logic      resetn_i,
   input  logic      ce_i,
   // Register port
   input  ifp_byte_t addr_i,
   input  ifp_byte_t wdata_i,
   input  logic      wr_i,
   input  logic      rd_i,
   output ifp_byte_t rdata_o,
   // Event pulses for the flags held here
   input  logic      sleep_timer_evt_i,
   input  logic      port_zero_evt_i,
   input  logic      timer_four_evt_i,
   input  logic      timer_three_evt_i,
   input  logic      timer_two_evt_i,
   input  logic      timer_one_evt_i,
   input  logic      dma_done_evt_i,
   input  logic      watchdog_evt_i,
   input  logic      port_one_evt_i,
   input  logic      usart_one_tx_evt_i,
   input  logic      usart_zero_tx_evt_i,
   input  logic      port_two_evt_i,
   // Pending levels of flags kept elsewhere
   input  logic      radio_txrx_done_source_i,
   input  logic      radio_general_source_i,
   input  logic      adc_source_i,
   input  logic      usart_zero_rx_source_i,
   input  logic      usart_one_rx_source_i,
   input  logic      aes_source_i,
   // CPU side
   output logic      irq_o,
   output ifp_num_t  irq_num_o,
   output ifp_lvl_t  irq_lvl_o,
   input  logic      ack_i,
   input  logic      reti_i,
   output logic [`IFP_NUM_LVL-1:0] in_service_o
);
   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   ifp_byte_t                prio_low_reg;
   ifp_byte_t                prio_high_reg;
   ifp_byte_t                rdata_reg;
   ifp_byte_t                flags_four;
   ifp_byte_t                flags_five;
   logic [`IFP_NUM_LVL-1:0]  in_service_reg;
   logic [`IFP_NUM_LVL-1:0]  in_service_next;
   logic                     irq_reg;
   ifp_num_t                 irq_num_reg;
   ifp_lvl_t                 irq_lvl_reg;
   logic                     ack_d_reg;

   // Address match per register
   wire sel_low  = (addr_i == `IFP_OFS_PRIO_LOW);
   wire sel_high = (addr_i == `IFP_OFS_PRIO_HIGH);
   wire sel_four = (addr_i == `IFP_OFS_FLAGS_FOUR);
   wire sel_five = (addr_i == `IFP_OFS_FLAGS_FIVE);
   wire wr_low   = wr_i & sel_low;
   wire wr_high  = wr_i & sel_high;
   wire wr_four  = wr_i & sel_four;
   wire wr_five  = wr_i & sel_five;

   // Unmapped addresses and unused bits read as zero
   wire ifp_byte_t rd_mux = sel_low  ? prio_low_reg  :
                            sel_high ? prio_high_reg :
                            sel_four ? flags_four    :
                            sel_five ? flags_five    : 8'h00;

   // ---------------------------------------------------------------
   // Pending flags
   // ---------------------------------------------------------------
   wire ack_take = ack_i & irq_o;

   // Hardware set terms, by bit position
   wire ifp_byte_t set_four = {sleep_timer_evt_i, 1'b0, port_zero_evt_i,     // [R1] [R2]
                               timer_four_evt_i, timer_three_evt_i,          // [R3]
                               timer_two_evt_i, timer_one_evt_i,
                               dma_done_evt_i};                              // [R4]
   wire ifp_byte_t set_five = {3'b000, watchdog_evt_i, port_one_evt_i,       // [R5] [R6]
                               usart_one_tx_evt_i, usart_zero_tx_evt_i,      // [R7]
                               port_two_evt_i};                              // [R8]

   // Only the timer flags clear themselves when the CPU vectors
   wire ifp_byte_t hwclr_four = {3'b000,
                                 ack_take && irq_num_reg == `IFP_N_T4,       // [R3]
                                 ack_take && irq_num_reg == `IFP_N_T3,
                                 ack_take && irq_num_reg == `IFP_N_T2,
                                 ack_take && irq_num_reg == `IFP_N_T1,
                                 1'b0};

   // Masked write data keeps unused bits at zero
   wire ifp_byte_t wdat_four = wdata_i & `IFP_MASK_FOUR;
   wire ifp_byte_t wdat_five = wdata_i & `IFP_MASK_FIVE;

   // One flag cell per bit of each flag register
   for (genvar gi = 0; gi < 8; gi++) begin : g_flag
      ifp_flag_bit u_four (
         .clk_sys_i (clk_sys_i),
         .resetn_i  (resetn_i),
         .ce_i      (ce_i),
         .set_i     (set_four[gi]),
         .wr_i      (wr_four),
         .wdata_i   (wdat_four[gi]),                                         // [R16]
         .hw_clr_i  (hwclr_four[gi]),
         .flag_o    (flags_four[gi])
      );
      ifp_flag_bit u_five (
         .clk_sys_i (clk_sys_i),
         .resetn_i  (resetn_i),
         .ce_i      (ce_i),
         .set_i     (set_five[gi]),
         .wr_i      (wr_five),
         .wdata_i   (wdat_five[gi]),
         .hw_clr_i  (1'b0),
         .flag_o    (flags_five[gi])
      );
   end

   // ---------------------------------------------------------------
   // Priority registers
   // ---------------------------------------------------------------
   // Six level pairs, one per group; top two bits never store
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prio_low_reg  <= `IFP_RST_PRIO;                                     // [R10]
         prio_high_reg <= `IFP_RST_PRIO;
      end else if (ce_i) begin
         if (wr_low) begin
            prio_low_reg <= wdata_i & `IFP_MASK_PRIO;                        // [R9]
         end
         if (wr_high) begin
            prio_high_reg <= wdata_i & `IFP_MASK_PRIO;
         end
      end
   end

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   ifp_src_vec_t pend;
   logic         arb_valid;
   ifp_num_t     arb_num;
   ifp_lvl_t     arb_lvl;

   // Requests placed at their interrupt numbers
   assign pend[`IFP_N_RADIO_TXRX_DONE_SOURCE] = radio_txrx_done_source_i;
   assign pend[`IFP_N_ADC]    = adc_source_i;
   assign pend[`IFP_N_URX0]   = usart_zero_rx_source_i;
   assign pend[`IFP_N_URX1]   = usart_one_rx_source_i;
   assign pend[`IFP_N_AES]    = aes_source_i;
   assign pend[`IFP_N_SLEEP]  = flags_four[`IFP_B4_SLEEP];
   assign pend[`IFP_N_P2]     = flags_five[`IFP_B5_PORT2];
   assign pend[`IFP_N_UTX0]   = flags_five[`IFP_B5_UTX0];
   assign pend[`IFP_N_DMA]    = flags_four[`IFP_B4_DMA];
   assign pend[`IFP_N_T1]     = flags_four[`IFP_B4_T1];
   assign pend[`IFP_N_T2]     = flags_four[`IFP_B4_T2];
   assign pend[`IFP_N_T3]     = flags_four[`IFP_B4_T3];
   assign pend[`IFP_N_T4]     = flags_four[`IFP_B4_T4];
   assign pend[`IFP_N_P0]     = flags_four[`IFP_B4_PORT0];
   assign pend[`IFP_N_UTX1]   = flags_five[`IFP_B5_UTX1];
   assign pend[`IFP_N_P1]     = flags_five[`IFP_B5_PORT1];
   assign pend[`IFP_N_RF]     = radio_general_source_i;
   assign pend[`IFP_N_WDT]    = flags_five[`IFP_B5_WDT];

   ifp_arbiter u_arb (
      .pend_i     (pend),
      .lvl_low_i  (prio_low_reg[`IFP_NUM_GRP-1:0]),
      .lvl_high_i (prio_high_reg[`IFP_NUM_GRP-1:0]),
      .valid_o    (arb_valid),
      .num_o      (arb_num),
      .lvl_o      (arb_lvl)
   );

   // ---------------------------------------------------------------
   // Preemption and service tracking
   // ---------------------------------------------------------------
   // Highest level now in service
   wire in_any = |in_service_reg;
   wire ifp_lvl_t active_lvl = in_service_reg[3] ? 2'h3 :
                               in_service_reg[2] ? 2'h2 :
                               in_service_reg[1] ? 2'h1 : 2'h0;

   // Only a strictly higher level may interrupt a running routine
   wire preempt_ok = arb_valid && (!in_any || arb_lvl > active_lvl);        // [R12]

   // Return drops the innermost level, vectoring adds the taken one
   wire [`IFP_NUM_LVL-1:0] top_onehot = 4'h1 << active_lvl;
   wire [`IFP_NUM_LVL-1:0] lvl_onehot = 4'h1 << irq_lvl_reg;
   assign in_service_next = (in_service_reg & ~((reti_i && in_any) ? top_onehot : 4'h0))
                          | (ack_take ? lvl_onehot : 4'h0);                 // [R12]

   // Winner is registered; the ack echo hides the one stale cycle
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_reg        <= 1'b0;
         irq_num_reg    <= '0;
         irq_lvl_reg    <= '0;
         ack_d_reg      <= 1'b0;
         in_service_reg <= '0;
      end else if (ce_i) begin
         irq_reg        <= preempt_ok;
         irq_num_reg    <= arb_num;
         irq_lvl_reg    <= arb_lvl;
         ack_d_reg      <= ack_take;
         in_service_reg <= in_service_next;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 8'h00;
      end else if (ce_i) begin
         rdata_reg <= rd_i ? rd_mux : 8'h00;
      end
   end

   assign rdata_o      = rdata_reg;
   assign irq_o        = irq_reg & ~ack_d_reg;
   assign irq_num_o    = irq_num_reg;
   assign irq_lvl_o    = irq_lvl_reg;
   assign in_service_o = in_service_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   property p_sleep_set;
      ce_i && sleep_timer_evt_i |=> flags_four[`IFP_B4_SLEEP];
   endproperty
   a_sleep_set: assert property (p_sleep_set) else $error("sleep flag not set"); // [R1]

   property p_port0_set;
      ce_i && port_zero_evt_i ##1 ce_i && rd_i && sel_four |=> rdata_o[`IFP_B4_PORT0];
   endproperty
   a_port0_set: assert property (p_port0_set) else $error("port 0 flag not read"); // [R2]

   property p_timer_clear;
      ce_i && ack_take && irq_num_reg == `IFP_N_T1 && !timer_one_evt_i && !wr_four
         |=> !flags_four[`IFP_B4_T1];
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept"); // [R3]

   property p_dma_kept;
      ce_i && flags_four[`IFP_B4_DMA] && !wr_four |=> flags_four[`IFP_B4_DMA];
   endproperty
   a_dma_kept: assert property (p_dma_kept) else $error("dma flag lost"); // [R4]

   property p_wdt_set;
      ce_i && watchdog_evt_i |=> flags_five[`IFP_B5_WDT] && pend[`IFP_N_WDT];
   endproperty
   a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag not set"); // [R5]

   property p_five_read;
      ce_i && rd_i && sel_five |=> rdata_o == ($past(flags_five) & `IFP_MASK_FIVE);
   endproperty
   a_five_read: assert property (p_five_read) else $error("flags five read wrong"); // [R6]

   property p_utx_set;
      ce_i && usart_zero_tx_evt_i && wr_five |=> flags_five[`IFP_B5_UTX0];
   endproperty
   a_utx_set: assert property (p_utx_set) else $error("tx flag lost to write"); // [R7]

   property p_port2_set;
      ce_i && port_two_evt_i |=> flags_five[`IFP_B5_PORT2];
   endproperty
   a_port2_set: assert property (p_port2_set) else $error("port 2 flag not set"); // [R8]

   property p_prio_write;
      ce_i && wr_i && sel_high |=> prio_high_reg == ($past(wdata_i) & `IFP_MASK_PRIO);
   endproperty
   a_prio_write: assert property (p_prio_write) else $error("level bits not stored"); // [R10]

   property p_no_preempt;
      irq_o && in_any |-> irq_lvl_o > active_lvl;
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("equal level preempted"); // [R12]

   property p_ack_level;
      ce_i && ack_take |=> in_service_reg[$past(irq_lvl_reg)] && !irq_o;
   endproperty
   a_ack_level: assert property (p_ack_level) else $error("service level not held"); // [R12]

   // A return must free the innermost level, or lower requests starve for good
   property p_reti_drop;
      ce_i && reti_i && in_any |=> !in_service_reg[$past(active_lvl)];
   endproperty
   a_reti_drop: assert property (p_reti_drop) else $error("level kept after return"); // [R12]

   // Covers: timer vectoring, nesting, polling tie, return, set beating a clear

   c_timer_taken: cover property (ack_take && irq_num_reg == `IFP_N_T3);
   c_nested:      cover property (in_service_reg[3] && in_service_reg[0]);
   c_tie:         cover property (flags_four[`IFP_B4_T1] && flags_four[`IFP_B4_DMA] && irq_o);
   c_return:      cover property (reti_i && in_any);
   c_set_wins:    cover property (usart_zero_tx_evt_i && wr_five);
endmodule

// >>> verification/ifp_cpu_model.sv
// Behavioural CPU core that takes interrupt requests and returns from them
`timescale 1ns/1ns
module ifp_cpu_model
   import ifp_pkg::*;
(
   // Clock and reset
   input  logic       clk_sys_i,
   input  logic       resetn_i,
   // Request from the interrupt block
   input  logic       irq_i,
   input  ifp_num_t   num_i,
   // Bench controls
   input  logic       take_i,
   input  logic [3:0] delay_i,
   input  logic       ret_i,
   // Answers to the interrupt block
   output logic       ack_o,
   output logic       reti_o,
   output ifp_num_t   taken_num_o
);
   // ---------------------------------------------------------------
   // Vectoring and return
   // ---------------------------------------------------------------
   logic [3:0] wait_reg;
   logic [3:0] depth_reg;

   // Ack only after irq has stood delay_i + 1 cycles, so slow cores are modelled too;
   // a return is only issued while some routine is open, as a real core would
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_reg    <= 4'h0;
         depth_reg   <= 4'h0;
         ack_o       <= 1'b0;
         reti_o      <= 1'b0;
         taken_num_o <= 5'h00;
      end else begin
         ack_o  <= 1'b0;
         reti_o <= ret_i && (depth_reg != 4'h0);
         if (ret_i && (depth_reg != 4'h0)) begin
            depth_reg <= depth_reg - 4'h1;
         end
         if (take_i && irq_i && !ack_o) begin
            if (wait_reg == delay_i) begin
               ack_o       <= 1'b1;
               wait_reg    <= 4'h0;
               taken_num_o <= num_i;
               depth_reg   <= depth_reg + 4'h1;
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end else begin
            wait_reg <= 4'h0;
         end
      end
   end
endmodule

// >>> verification/interrupt_flags_and_priority_tb.sv
// Self-checking bench for the interrupt flag and priority block
`timescale 1ns/1ns
`include "ifp_defines.svh"
module interrupt_flags_and_priority_tb
   import ifp_pkg::*;
;
   typedef struct {ifp_byte_t addr; ifp_byte_t mask; ifp_num_t num;} ifp_tb_row_t;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       clk_sys_i;
   logic       resetn_i;
   logic       ce_i;
   ifp_byte_t  addr_i;
   ifp_byte_t  wdata_i;
   logic       wr_i;
   logic       rd_i;
   ifp_byte_t  rdata_o;
   logic [11:0] evt;
   logic [5:0] ext;
   logic       irq_o;
   ifp_num_t   irq_num_o;
   ifp_lvl_t   irq_lvl_o;
   logic       ack_i;
   logic       reti_i;
   logic [3:0] in_service_o;
   logic       take;
   logic       ret;
   ifp_num_t   taken_num;
   ifp_byte_t  rv;
   ifp_byte_t  e4;
   ifp_byte_t  e5;
   int         fail_count;
   int         checks;

   // Event sources, indexed in polling order
   ifp_tb_row_t rows [12] = '{
      '{`IFP_OFS_FLAGS_FOUR, 8'h01, 5'h08}, '{`IFP_OFS_FLAGS_FOUR, 8'h02, 5'h09},
      '{`IFP_OFS_FLAGS_FOUR, 8'h04, 5'h0a}, '{`IFP_OFS_FLAGS_FOUR, 8'h08, 5'h0b},
      '{`IFP_OFS_FLAGS_FOUR, 8'h10, 5'h0c}, '{`IFP_OFS_FLAGS_FOUR, 8'h80, 5'h05},
      '{`IFP_OFS_FLAGS_FOUR, 8'h20, 5'h0d}, '{`IFP_OFS_FLAGS_FIVE, 8'h01, 5'h06},
      '{`IFP_OFS_FLAGS_FIVE, 8'h02, 5'h07}, '{`IFP_OFS_FLAGS_FIVE, 8'h04, 5'h0e},
      '{`IFP_OFS_FLAGS_FIVE, 8'h08, 5'h0f}, '{`IFP_OFS_FLAGS_FIVE, 8'h10, 5'h11}};
   // Outside sources in port order, which is also their polling order
   ifp_num_t ext_num [6] = '{5'h00, 5'h10, 5'h01, 5'h02, 5'h03, 5'h04};
   ifp_byte_t rst_addr [5] = '{8'ha9, 8'hb9, 8'hc0, 8'he8, 8'ha8};

   // ---------------------------------------------------------------
   // Design and CPU model
   // ---------------------------------------------------------------
   ifp_top i_dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sleep_timer_evt_i(evt[5]), .port_zero_evt_i(evt[6]), .timer_four_evt_i(evt[4]),
      .timer_three_evt_i(evt[3]), .timer_two_evt_i(evt[2]), .timer_one_evt_i(evt[1]),
      .dma_done_evt_i(evt[0]), .watchdog_evt_i(evt[11]), .port_one_evt_i(evt[10]),
      .usart_one_tx_evt_i(evt[9]), .usart_zero_tx_evt_i(evt[8]), .port_two_evt_i(evt[7]),
      .radio_txrx_done_source_i(ext[0]), .radio_general_source_i(ext[1]),
      .adc_source_i(ext[2]), .usart_zero_rx_source_i(ext[3]),
      .usart_one_rx_source_i(ext[4]), .aes_source_i(ext[5]),
      .irq_o(irq_o), .irq_num_o(irq_num_o), .irq_lvl_o(irq_lvl_o),
      .ack_i(ack_i), .reti_i(reti_i), .in_service_o(in_service_o));

   ifp_cpu_model i_cpu (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .irq_i(irq_o), .num_i(irq_num_o),
      .take_i(take), .delay_i(4'h2), .ret_i(ret), .ack_o(ack_i), .reti_o(reti_i),
      .taken_num_o(taken_num));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task wr(input ifp_byte_t a, input ifp_byte_t d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      wr_i    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task rd(input ifp_byte_t a);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i   <= 1'b0;
      #1;
      rv = rdata_o;
   endtask

   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task pulse(input logic [11:0] v);
      @(posedge clk_sys_i);
      evt <= v;
      @(posedge clk_sys_i);
      evt <= 12'h000;
   endtask

   task test_done;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // Whole run is a few hundred cycles; this leaves a wide margin
   initial begin
      #2000000;
      fail_count++;
      test_done;
   end

   initial begin
      int i;
      int l;
      resetn_i = 1'b0; ce_i = 1'b1; addr_i = 8'h00; wdata_i = 8'h00; wr_i = 1'b0;
      rd_i = 1'b0; evt = 12'h000; ext = 6'h00; take = 1'b0; ret = 1'b0;
      fail_count = 0; checks = 0; e4 = 8'h00; e5 = 8'h00;
      repeat (16) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      // Reset values, and an unmapped address reads zero
      for (i = 0; i < 5; i++) begin
         rd(rst_addr[i]);
         check(rv, 8'h00);
      end
      // Frozen clock enable drops a write; unused level bits read zero
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      wr(`IFP_OFS_PRIO_LOW, 8'h3f);
      ce_i <= 1'b1;
      rd(`IFP_OFS_PRIO_LOW);
      check(rv, 8'h00);
      wr(`IFP_OFS_PRIO_HIGH, 8'hff);
      rd(`IFP_OFS_PRIO_HIGH);
      check(rv, 8'h3f);
      wr(`IFP_OFS_PRIO_HIGH, 8'h00);
      // Each event alone: flag position, winner number, software clear
      for (i = 0; i < 12; i++) begin
         pulse(12'h001 << i);
         tick(2);
         rd(rows[i].addr);
         check(rv, rows[i].mask);
         check({3'b000, irq_num_o}, {3'b000, rows[i].num});
         wr(rows[i].addr, 8'h00);
         tick(3);
         check({7'h00, irq_o}, 8'h00);
      end
      // Outside sources dropped one at a time in polling order
      for (i = 0; i < 6; i++) begin
         @(posedge clk_sys_i);
         ext <= 6'h3f << i;
         tick(3);
         check({3'b000, irq_num_o}, {3'b000, ext_num[i]});
      end
      @(posedge clk_sys_i);
      ext <= 6'h00;
      // All held flags at once, same level: served in polling order
      pulse(12'hfff);
      e4 = 8'hbf;
      e5 = 8'h1f;
      tick(3);
      for (i = 0; i < 12; i++) begin
         check({7'h00, irq_o}, 8'h01);
         check({3'b000, irq_num_o}, {3'b000, rows[i].num});
         if (rows[i].addr == `IFP_OFS_FLAGS_FOUR) begin
            e4 = e4 & ~rows[i].mask;
            wr(`IFP_OFS_FLAGS_FOUR, e4);
         end else begin
            e5 = e5 & ~rows[i].mask;
            wr(`IFP_OFS_FLAGS_FIVE, e5);
         end
         tick(3);
      end
      check({7'h00, irq_o}, 8'h00);
      // Timer 1 and DMA: the group 1 level decides, ties go to DMA
      pulse(12'h003);
      for (l = 0; l < 4; l++) begin
         wr(`IFP_OFS_PRIO_LOW, {6'h00, l[0], 1'b0});
         wr(`IFP_OFS_PRIO_HIGH, {6'h00, l[1], 1'b0});
         tick(3);
         check({3'b000, irq_num_o}, (l == 0) ? 8'h08 : 8'h09);
         check({6'h00, irq_lvl_o}, l[7:0]);
      end
      // Vectoring to timer 1 clears its flag only; DMA cannot preempt
      @(posedge clk_sys_i);
      take <= 1'b1;
      for (i = 0; i < 20 && in_service_o === 4'h0; i++) begin
         tick(1);
      end
      take <= 1'b0;
      check({4'h0, in_service_o}, 8'h08);
      check({3'b000, taken_num}, 8'h09);
      rd(`IFP_OFS_FLAGS_FOUR);
      check(rv, 8'h01);
      tick(2);
      check({7'h00, irq_o}, 8'h00);
      wr(`IFP_OFS_PRIO_LOW, 8'h03);
      wr(`IFP_OFS_PRIO_HIGH, 8'h03);
      tick(3);
      check({7'h00, irq_o}, 8'h00);
      // Return lets the waiting DMA request through
      @(posedge clk_sys_i);
      ret <= 1'b1;
      @(posedge clk_sys_i);
      ret <= 1'b0;
      tick(4);
      check({4'h0, in_service_o}, 8'h00);
      check({7'h00, irq_o}, 8'h01);
      check({3'b000, irq_num_o}, 8'h08);
      // Events in a clearing write keep their flags; read right behind an event
      @(posedge clk_sys_i);
      evt     <= 12'h140;
      addr_i  <= `IFP_OFS_FLAGS_FIVE;
      wdata_i <= 8'h00;
      wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      evt    <= 12'h000;
      wr_i   <= 1'b0;
      addr_i <= `IFP_OFS_FLAGS_FOUR;
      rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, 8'h21);
      rd(`IFP_OFS_FLAGS_FIVE);
      check(rv, 8'h02);
      // Reset in mid-run drops the pending flags read back from flags four, and the request
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      tick(2);
      resetn_i <= 1'b1;
      rd(`IFP_OFS_FLAGS_FOUR);
      check(rv, 8'h00);
      check({7'h00, irq_o}, 8'h00);
      test_done;
   end
endmodule
